// ### fdc_pm_seq.sv
// Powerdown, wake decode and PLL select logic of the floppy controller
//
// Summary of operation
// - Reset wake runs ordinary reset sequence
// - Register wake keeps state intact, except wake from direct powerdown clears the powerdown bit
// - Motor enable write wakes; read does not
// - Main status read wakes
// - Data port read or write wakes
// - Software reset bit write wakes
// - Other control writes do not wake
// - Wake restarts 10 ms powerdown timer
// - Re-enter powerdown when conditions met again
// - Listed registers accessible without waking
// - Non-waking reads return true status
// - Non-waking writes stored, effective on wake
// - Return to low power after access
// - Supply not good: host decode disabled
// - Event pins live while trickle powered
// - Supply good selects infrared clock, timeout
// - Trickle logic has its own reset
// - Event power bit powers 32 kHz PLL
// - PLL control bit powers down both
// - Good, no event: 14 MHz only
// - Event, not good: 32 kHz only
// - Event and good: both, 14 MHz selected
// - Bus pins live, requests held low
// - Drive pins disabled in powerdown
// - Disabling auto powerdown cancels timer
// - Direct powerdown overrides, auto resumes after
`timescale 1ns/10ps
module fdc_pm_seq
	import fdc_pm_pkg::*;
#(
	parameter int PD_CYCLES = PD_TIMER_CYCLES
) (
	// Clock and resets
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic TRICKLE_POR,
	// Host I/O bus, already qualified by base address decode
	input wire logic CS_IN,
	input wire logic IOR_N,
	input wire logic IOW_N,
	input wire logic [2:0] SA,
	input wire logic [7:0] SD_IN,
	output logic [7:0] SD_OUT,
	output logic SD_OE,
	// Host reset and supply status
	input wire logic HOST_RESET_INPUT,
	input wire logic INTERNAL_SUPPLY_GOOD,
	// Configuration bits
	input wire logic AUTO_PD_ENABLE,
	input wire logic POWER_CONTROL_CONFIG_7,
	input wire logic PLL_CONFIG_1,
	// Controller core status
	input wire logic CORE_IDLE,
	input wire logic CORE_INT,
	input wire logic HEAD_UNLOADED,
	input wire logic [7:0] MAIN_STATUS_IN,
	input wire logic [7:0] STATUS_A_IN,
	input wire logic [7:0] STATUS_B_IN,
	input wire logic [7:0] DRIVE_INPUT_IN,
	input wire logic [7:0] DATA_IN,
	input wire logic IRQ_CORE,
	input wire logic DRQ_CORE,
	// Controller core control
	output logic DATA_RD,
	output logic DATA_WR,
	output logic [7:0] DATA_OUT,
	output logic [7:0] DRIVE_OUTPUT_CONTROL,
	output logic [7:0] RATE_SELECT_CONTROL,
	output logic [7:0] RATE_CONFIG_WRITE,
	output logic CORE_RESET,
	output logic CORE_CLK_EN,
	output logic POWERED_DOWN,
	// Host request outputs
	output logic IRQ,
	output logic DRQ,
	// Drive interface enable
	output logic DRIVE_PINS_EN,
	// Clocking controls for the event logic
	output logic PLL14_POWER,
	output logic PLL32_POWER,
	output logic PLL32_SELECT,
	output logic IR_CLK_FROM_SUPPLY,
	output logic IR_TIMEOUT_EN,
	output logic TRICKLE_RESET
);
	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	typedef enum logic [1:0] {ST_RESET, ST_AWAKE, ST_AUTO_PD, ST_DIRECT_PD} pm_state_e;
	pm_state_e state_ff;
	pm_state_e nxt_state;
	logic [1:0] rst_sync_ff;
	logic [1:0] pg_sync_ff;
	logic [2:0] ior_sync_ff;
	logic [2:0] iow_sync_ff;
	logic [1:0] cs_sync_ff;
	logic [7:0] doc_ff;
	logic [7:0] rsc_ff;
	logic [7:0] rcw_ff;
	logic [31:0] pd_timer_ff;
	logic [2:0] rst_cnt_ff;
	logic [7:0] sd_out_ff;
	logic sd_oe_ff;
	logic [7:0] data_out_ff;
	logic data_rd_ff;
	logic data_wr_ff;
	logic [1:0] trk_por_ff;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic motors_on(input logic [7:0] v);
		motors_on = |v[7:DOC_MOTOR_LO];
	endfunction : motors_on

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		rst_sync_ff <= {rst_sync_ff[0], HOST_RESET_INPUT};
		pg_sync_ff <= {pg_sync_ff[0], INTERNAL_SUPPLY_GOOD};
		ior_sync_ff <= {ior_sync_ff[1:0], ~IOR_N};
		iow_sync_ff <= {iow_sync_ff[1:0], ~IOW_N};
		cs_sync_ff <= {cs_sync_ff[0], CS_IN};
	end

	logic supply_good;
	logic hw_reset;
	logic rd_strobe;
	logic wr_strobe;
	assign supply_good = pg_sync_ff[1];
	assign hw_reset = rst_sync_ff[1];
	// Strobe edges taken from stage two and three only; decode gated by supply good
	assign rd_strobe = ior_sync_ff[1] & ~ior_sync_ff[2] & cs_sync_ff[1] & supply_good;
	assign wr_strobe = iow_sync_ff[1] & ~iow_sync_ff[2] & cs_sync_ff[1] & supply_good;

	// ----------------------------------------
	// Address and write data capture
	// ----------------------------------------
	// Two stages keep the bus fields aligned with the strobe synchronisers
	logic [2:0] sa_s1_ff;
	logic [2:0] sa_s2_ff;
	logic [7:0] sd_s1_ff;
	logic [7:0] sd_s2_ff;
	logic [2:0] sa_q;
	logic [7:0] sd_q;
	always_ff @(posedge MCLK) begin
		sa_s1_ff <= SA;
		sa_s2_ff <= sa_s1_ff;
		sd_s1_ff <= SD_IN;
		sd_s2_ff <= sd_s1_ff;
	end
	assign sa_q = sa_s2_ff;
	assign sd_q = sd_s2_ff;

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic wr_doc;
	logic wr_rsc;
	logic wr_rcw;
	logic rd_main;
	logic acc_data;
	logic sw_reset;
	logic wake_access;
	logic pd_request;
	assign wr_doc = wr_strobe && sa_q == OFS_DRIVE_OUTPUT;
	assign wr_rsc = wr_strobe && sa_q == OFS_RATE_MAIN;
	assign wr_rcw = wr_strobe && sa_q == OFS_DRIVE_INPUT;
	assign rd_main = rd_strobe && sa_q == OFS_RATE_MAIN;
	assign acc_data = (rd_strobe | wr_strobe) && sa_q == OFS_DATA_PORT;
	assign sw_reset = (wr_doc & ~sd_q[DOC_RESET_N_BIT]) | (wr_rsc & sd_q[RSC_SWRESET_BIT]);
	assign pd_request = wr_rsc && sd_q[RSC_POWERDOWN_BIT];

	// ----------------------------------------
	// Wake decode
	// ----------------------------------------
	// Plain control writes fall through without waking
	assign wake_access = (wr_doc & motors_on(sd_q)) | rd_main | acc_data;

	// ----------------------------------------
	// Shadowed control registers
	// ----------------------------------------
	logic [7:0] rsc_next_val;
	// Software reset bit acts as a strobe and is never stored
	assign rsc_next_val = sd_q & ~(8'h01 << RSC_SWRESET_BIT);
	always_ff @(posedge MCLK) begin
		if (RESET || hw_reset) begin
			doc_ff <= DOC_RESET;
			rsc_ff <= RSC_RESET;
			rcw_ff <= RCW_RESET;
		end else begin
			if (wr_doc)
				doc_ff <= sd_q;
			if (wr_rsc)
				rsc_ff <= rsc_next_val;
			else if (state_ff == ST_DIRECT_PD && wake_access)
				rsc_ff[RSC_POWERDOWN_BIT] <= 1'b0;
			if (wr_rcw)
				rcw_ff <= sd_q;
		end
	end

	// ----------------------------------------
	// Powerdown timer
	// ----------------------------------------
	logic pd_conds;
	logic timer_done;
	logic core_quiet;
	assign timer_done = pd_timer_ff == 32'h0000_0000;
	// Idle core: no motors, no pending interrupt, head unloaded
	assign core_quiet = !motors_on(doc_ff) && CORE_IDLE && MAIN_STATUS_IN == IDLE_MAIN_STATUS && !CORE_INT
		&& HEAD_UNLOADED;
	assign pd_conds = AUTO_PD_ENABLE && core_quiet && timer_done;
	always_ff @(posedge MCLK) begin
		if (RESET || !AUTO_PD_ENABLE)
			pd_timer_ff <= 32'(PD_CYCLES);
		else if (state_ff != ST_AWAKE)
			pd_timer_ff <= 32'(PD_CYCLES);
		else if (!timer_done)
			pd_timer_ff <= pd_timer_ff - 32'h0000_0001;
	end

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RESET: begin
				if (rst_cnt_ff == 3'h0 && !hw_reset)
					nxt_state = ST_AWAKE;
			end
			ST_AWAKE: begin
				if (pd_request)
					nxt_state = ST_DIRECT_PD;
				else if (pd_conds && !wake_access)
					nxt_state = ST_AUTO_PD;
			end
			ST_AUTO_PD: begin
				if (pd_request)
					nxt_state = ST_DIRECT_PD;
				else if (wake_access)
					nxt_state = ST_AWAKE;
			end
			ST_DIRECT_PD: begin
				if (wake_access)
					nxt_state = ST_AWAKE;
			end
			default: nxt_state = ST_RESET;
		endcase
		// Non-waking accesses other than a powerdown bit write leave the state untouched
		if (hw_reset || sw_reset)
			nxt_state = ST_RESET;
		if (!AUTO_PD_ENABLE && nxt_state == ST_AUTO_PD)
			nxt_state = ST_AWAKE;
	end

	always_ff @(posedge MCLK) begin
		if (RESET)
			state_ff <= ST_RESET;
		else
			state_ff <= nxt_state;
	end

	// ----------------------------------------
	// Reset sequence counter
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RESET || hw_reset || sw_reset)
			rst_cnt_ff <= 3'(RESET_SEQ_CYCLES);
		else if (rst_cnt_ff != 3'h0)
			rst_cnt_ff <= rst_cnt_ff - 3'h1;
	end

	// ----------------------------------------
	// Host read data, same cycle as any wake
	// ----------------------------------------
	// Read multiplexer, the same while asleep and awake
	function automatic logic [7:0] read_mux(input logic [2:0] a);
		case (a)
			OFS_STATUS_A: read_mux = STATUS_A_IN;
			OFS_STATUS_B: read_mux = STATUS_B_IN;
			OFS_DRIVE_OUTPUT: read_mux = doc_ff;
			OFS_RATE_MAIN: read_mux = MAIN_STATUS_IN;
			OFS_DATA_PORT: read_mux = DATA_IN;
			OFS_DRIVE_INPUT: read_mux = DRIVE_INPUT_IN;
			default: read_mux = 8'h00;
		endcase
	endfunction : read_mux

	always_ff @(posedge MCLK) begin
		if (RESET)
			sd_oe_ff <= 1'b0;
		else
			sd_oe_ff <= ior_sync_ff[1] & cs_sync_ff[1] & supply_good;
	end

	always_ff @(posedge MCLK) begin
		if (RESET)
			sd_out_ff <= 8'h00;
		else if (rd_strobe)
			sd_out_ff <= read_mux(sa_q);
	end

	// ----------------------------------------
	// Core data port strobes
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			data_rd_ff <= 1'b0;
			data_wr_ff <= 1'b0;
			data_out_ff <= 8'h00;
		end else begin
			data_rd_ff <= acc_data & rd_strobe;
			data_wr_ff <= acc_data & wr_strobe;
			if (acc_data & wr_strobe)
				data_out_ff <= sd_q;
		end
	end

	// ----------------------------------------
	// Trickle domain reset
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		trk_por_ff <= {trk_por_ff[0], TRICKLE_POR};
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic asleep;
	assign asleep = state_ff == ST_AUTO_PD || state_ff == ST_DIRECT_PD;
	assign SD_OUT = sd_out_ff;
	assign SD_OE = sd_oe_ff;
	assign DATA_RD = data_rd_ff;
	assign DATA_WR = data_wr_ff;
	assign DATA_OUT = data_out_ff;
	assign DRIVE_OUTPUT_CONTROL = doc_ff;
	assign RATE_SELECT_CONTROL = rsc_ff;
	assign RATE_CONFIG_WRITE = rcw_ff;
	assign CORE_RESET = state_ff == ST_RESET;
	// Core clock stays off after a non-waking access
	assign CORE_CLK_EN = !asleep;
	assign POWERED_DOWN = asleep;

	// ----------------------------------------
	// Host requests and drive pins
	// ----------------------------------------
	assign IRQ = IRQ_CORE & !asleep;
	assign DRQ = DRQ_CORE & !asleep;
	assign DRIVE_PINS_EN = !asleep;

	// ----------------------------------------
	// PLL and infrared clock selection
	// ----------------------------------------
	// PLL table: control bit forces all off, otherwise supply good picks 14 MHz
	assign PLL14_POWER = !PLL_CONFIG_1 && supply_good;
	assign PLL32_POWER = !PLL_CONFIG_1 && POWER_CONTROL_CONFIG_7;
	assign PLL32_SELECT = !PLL_CONFIG_1 && POWER_CONTROL_CONFIG_7 && !supply_good;
	assign IR_CLK_FROM_SUPPLY = supply_good;
	assign IR_TIMEOUT_EN = supply_good;

	// ----------------------------------------
	// Event logic reset
	// ----------------------------------------
	// Event logic reset only by its own power-on, never by supply loss
	assign TRICKLE_RESET = trk_por_ff[1];
endmodule : fdc_pm_seq

// ### fdc_pm_pkg.sv
// Package of constants for the floppy controller powerdown and wake sequencer
package fdc_pm_pkg;
	// ----------------------------------------
	// Register offsets (base + offset)
	// ----------------------------------------
	localparam logic [2:0] OFS_STATUS_A = 3'h0;
	localparam logic [2:0] OFS_STATUS_B = 3'h1;
	localparam logic [2:0] OFS_DRIVE_OUTPUT = 3'h2;
	localparam logic [2:0] OFS_RATE_MAIN = 3'h4;
	localparam logic [2:0] OFS_DATA_PORT = 3'h5;
	localparam logic [2:0] OFS_DRIVE_INPUT = 3'h7;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DOC_RESET_N_BIT = 2;
	localparam int DOC_MOTOR_LO = 4;
	localparam int RSC_SWRESET_BIT = 7;
	localparam int RSC_POWERDOWN_BIT = 6;
	localparam int EVENT_POWER_BIT = 7;
	localparam int PLL_CTRL_BIT = 1;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] DOC_RESET = 8'h00;
	localparam logic [7:0] RSC_RESET = 8'h02;
	localparam logic [7:0] RCW_RESET = 8'h02;
	localparam logic [7:0] IDLE_MAIN_STATUS = 8'h80;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PD_TIMER_MS = 10;
	localparam int PD_TIMER_CYCLES = PD_TIMER_MS * 1000000 / CLK_PERIOD_NS;
	localparam int RESET_SEQ_CYCLES = 4;
endpackage : fdc_pm_pkg

// ### fdc_pm_seq_assertions.sv
// Port checker for the powerdown and wake sequencer
`timescale 1ns/10ps
module fdc_pm_seq_chk
	import fdc_pm_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Host side
	input wire logic [2:0] SA,
	input wire logic SD_OE,
	input wire logic INTERNAL_SUPPLY_GOOD,
	// Config
	input wire logic POWER_CONTROL_CONFIG_7,
	input wire logic PLL_CONFIG_1,
	// Watched outputs
	input wire logic POWERED_DOWN,
	input wire logic CORE_RESET,
	input wire logic IRQ,
	input wire logic DRQ,
	input wire logic DRIVE_PINS_EN,
	input wire logic PLL14_POWER,
	input wire logic PLL32_POWER
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	chk_req_gate: assert property (POWERED_DOWN |-> !IRQ && !DRQ) else $error("request out while asleep");
	chk_drive_pins_off: assert property (POWERED_DOWN |-> !DRIVE_PINS_EN) else $error("drive pins on");
	chk_pll_ctrl_off: assert property (PLL_CONFIG_1 |-> !PLL14_POWER && !PLL32_POWER) else $error("pll on");
	chk_event_power: assert property (!PLL_CONFIG_1 |-> PLL32_POWER == POWER_CONTROL_CONFIG_7)
		else $error("slow pll power wrong");
	chk_good_pll14: assert property ((INTERNAL_SUPPLY_GOOD && !PLL_CONFIG_1)[*5] |-> PLL14_POWER)
		else $error("fast pll off");
	chk_no_decode: assert property ((!INTERNAL_SUPPLY_GOOD)[*6] |-> !SD_OE) else $error("decode without supply");
	chk_reset_seq: assert property ($fell(RESET) |-> CORE_RESET[*3] ##[1:3] !CORE_RESET)
		else $error("reset sequence length");
	chk_status_wake: assert property ($rose(SD_OE) && SA == OFS_RATE_MAIN && $past(POWERED_DOWN)
		|-> !POWERED_DOWN) else $error("status read kept sleep");
	chk_data_wake: assert property ($rose(SD_OE) && SA == OFS_DATA_PORT && $past(POWERED_DOWN)
		|-> !POWERED_DOWN) else $error("data read kept sleep");
	chk_status_a_sleep: assert property ($rose(SD_OE) && SA == OFS_STATUS_A && $past(POWERED_DOWN)
		|-> POWERED_DOWN) else $error("status a read woke");
endmodule : fdc_pm_seq_chk

// ### isa_host_model.sv
// Host I/O bus model issuing single byte accesses
`timescale 1ns/10ps
module isa_host_model (
	// Clock
	input wire logic clk,
	// Strobes and address
	output logic cs = 1'b0,
	output logic ior_n = 1'b1,
	output logic iow_n = 1'b1,
	output logic [2:0] sa = 3'h0,
	// Data
	output logic [7:0] sd_in = 8'h00,
	input wire logic [7:0] sd_out,
	input wire logic sd_oe
);
	// Released data is inverted so a stale byte never reads as valid
	task automatic io(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic oe);
		q = 8'h00;
		oe = 1'b0;
		@(posedge clk);
		cs <= 1'b1;
		sa <= a;
		sd_in <= d;
		@(posedge clk);
		ior_n <= wr;
		iow_n <= !wr;
		repeat (6) begin
			@(negedge clk);
			if (sd_oe === 1'b1) begin
				oe = 1'b1;
				q = sd_out;
			end
		end
		@(posedge clk);
		ior_n <= 1'b1;
		iow_n <= 1'b1;
		@(posedge clk);
		cs <= 1'b0;
		sd_in <= ~d;
		repeat (5) @(posedge clk);
	endtask : io
endmodule : isa_host_model

// ### tb_top.sv
// Self-checking bench for the powerdown and wake sequencer
`timescale 1ns/10ps
module tb_top;
	import fdc_pm_pkg::*;
	localparam int PD = 20;
	logic clk = 1'b0, rst = 1'b1, por = 1'b1, hrst = 1'b0, good = 1'b1, auto_pd = 1'b1;
	logic evp = 1'b0, pllc = 1'b0, idle = 1'b1, cint = 1'b0, irqc = 1'b0;
	logic cs, ior_n, iow_n, sdoe, crst, pd, irq, drq, dpe, p14, p32, sel, iren, trst, irclk, cken, drd, dwr;
	logic [2:0] sa;
	logic [7:0] sdi, sdo, doc, rsc, rcw, dout;
	int error_cnt = 0, num_checks = 0, rst_cnt = 0, drd_cnt = 0, dwr_cnt = 0;
	always #5 clk = ~clk;
	always @(posedge clk) if (crst === 1'b1) rst_cnt <= rst_cnt + 1;
	always @(posedge clk) begin
		if (drd === 1'b1) drd_cnt <= drd_cnt + 1;
		if (dwr === 1'b1) dwr_cnt <= dwr_cnt + 1;
	end
	isa_host_model host (.clk(clk), .cs(cs), .ior_n(ior_n), .iow_n(iow_n), .sa(sa), .sd_in(sdi),
		.sd_out(sdo), .sd_oe(sdoe));
	fdc_pm_seq #(.PD_CYCLES(PD)) uut (.MCLK(clk), .RESET(rst), .TRICKLE_POR(por), .CS_IN(cs), .IOR_N(ior_n),
		.IOW_N(iow_n), .SA(sa), .SD_IN(sdi), .SD_OUT(sdo), .SD_OE(sdoe), .HOST_RESET_INPUT(hrst),
		.INTERNAL_SUPPLY_GOOD(good), .AUTO_PD_ENABLE(auto_pd), .POWER_CONTROL_CONFIG_7(evp), .PLL_CONFIG_1(pllc),
		.CORE_IDLE(idle), .CORE_INT(cint), .HEAD_UNLOADED(idle), .MAIN_STATUS_IN(IDLE_MAIN_STATUS),
		.STATUS_A_IN(8'hC3), .STATUS_B_IN(8'h5A), .DRIVE_INPUT_IN(8'hA5), .DATA_IN(8'h3C), .IRQ_CORE(irqc),
		.DRQ_CORE(irqc), .DATA_RD(drd), .DATA_WR(dwr), .DATA_OUT(dout), .DRIVE_OUTPUT_CONTROL(doc),
		.RATE_SELECT_CONTROL(rsc), .RATE_CONFIG_WRITE(rcw), .CORE_RESET(crst), .CORE_CLK_EN(cken),
		.POWERED_DOWN(pd), .IRQ(irq), .DRQ(drq), .DRIVE_PINS_EN(dpe), .PLL14_POWER(p14), .PLL32_POWER(p32),
		.PLL32_SELECT(sel), .IR_CLK_FROM_SUPPLY(irclk),
		.IR_TIMEOUT_EN(iren), .TRICKLE_RESET(trst));
	task finish_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask : ck
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic oe;
		host.io(1'b0, a, 8'h00, q, oe);
		ck({7'h00, oe}, 8'h01);
		ck(q, e);
	endtask : rd
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic oe;
		host.io(1'b1, a, d, q, oe);
	endtask : wr
	// Bounded wait for the sleep flag to reach a level
	task automatic wpd(input logic v, output int c);
		c = 0;
		while (pd !== v) begin
			@(negedge clk);
			c++;
			if (c > 300) begin
				error_cnt++;
				$display("unexpected %0t wait timeout", $time);
				finish_test();
			end
		end
		@(posedge clk);
	endtask : wpd
	task automatic t_asleep;
		int c;
		wpd(1'b1, c);
		irqc <= 1'b1;
		rd(OFS_STATUS_A, 8'hC3);
		rd(OFS_STATUS_B, 8'h5A);
		rd(3'h3, 8'h00);
		rd(OFS_DRIVE_INPUT, 8'hA5);
		rd(OFS_DRIVE_OUTPUT, 8'h0C);
		ck({5'h00, pd, irq, drq}, 8'h04);
		ck({6'h00, dpe, cken}, 8'h00);
		irqc <= 1'b0;
	endtask : t_asleep
	task automatic t_store;
		int c;
		wr(OFS_DRIVE_OUTPUT, 8'h0D);
		wr(OFS_RATE_MAIN, 8'h01);
		wr(OFS_DRIVE_INPUT, 8'h01);
		ck({7'h00, pd}, 8'h01);
		rd(OFS_RATE_MAIN, IDLE_MAIN_STATUS);
		ck({6'h00, pd, crst}, 8'h00);
		ck(doc, 8'h0D);
		ck(rsc, 8'h01);
		ck(rcw, 8'h01);
		wpd(1'b1, c);
		wr(OFS_DRIVE_OUTPUT, 8'h1D);
		ck({7'h00, pd}, 8'h00);
		wr(OFS_DRIVE_OUTPUT, 8'h0D);
	endtask : t_store
	task automatic t_data;
		int c, n;
		wpd(1'b1, c);
		n = drd_cnt;
		rd(OFS_DATA_PORT, 8'h3C);
		ck({7'h00, pd}, 8'h00);
		ck(8'(drd_cnt - n), 8'h01);
		wpd(1'b1, c);
		ck({7'h00, c > 4 && c < PD}, 8'h01);
		n = dwr_cnt;
		wr(OFS_DATA_PORT, 8'h5A);
		ck({7'h00, pd}, 8'h00);
		ck(8'(dwr_cnt - n), 8'h01);
		ck(dout, 8'h5A);
	endtask : t_data
	task automatic t_swreset;
		int c, n;
		wpd(1'b1, c);
		n = rst_cnt;
		wr(OFS_RATE_MAIN, 8'h81);
		ck({6'h00, pd, rst_cnt - n >= RESET_SEQ_CYCLES}, 8'h01);
		wpd(1'b1, c);
		n = rst_cnt;
		wr(OFS_DRIVE_OUTPUT, 8'h08);
		ck({6'h00, pd, rst_cnt - n >= RESET_SEQ_CYCLES}, 8'h01);
		wr(OFS_DRIVE_OUTPUT, 8'h0C);
		wpd(1'b1, c);
		n = rst_cnt;
		hrst <= 1'b1;
		repeat (4) @(posedge clk);
		hrst <= 1'b0;
		repeat (12) @(posedge clk);
		ck({6'h00, pd, rst_cnt - n >= RESET_SEQ_CYCLES}, 8'h01);
		ck(doc, DOC_RESET);
		wr(OFS_DRIVE_OUTPUT, 8'h0C);
	endtask : t_swreset
	task automatic t_direct;
		int c;
		auto_pd <= 1'b0;
		repeat (60) @(negedge clk);
		ck({7'h00, pd}, 8'h00);
		wr(OFS_RATE_MAIN, 8'h41);
		wpd(1'b1, c);
		rd(OFS_RATE_MAIN, IDLE_MAIN_STATUS);
		ck({7'h00, pd}, 8'h00);
		auto_pd <= 1'b1;
		wpd(1'b1, c);
		rd(OFS_RATE_MAIN, IDLE_MAIN_STATUS);
		cint <= 1'b1;
		repeat (60) @(negedge clk);
		ck({7'h00, pd}, 8'h00);
		@(posedge clk);
		cint <= 1'b0;
		wpd(1'b1, c);
	endtask : t_direct
	task automatic t_pll;
		logic [7:0] q;
		logic oe;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			pllc <= i[2];
			evp <= i[1];
			good <= i[0];
			repeat (5) @(negedge clk);
			ck({5'h00, p14, p32, sel}, {5'h00, !i[2] && i[0], !i[2] && i[1], !i[2] && i[1] && !i[0]});
			ck({6'h00, iren, irclk}, {6'h00, i[0], i[0]});
		end
		@(posedge clk);
		good <= 1'b0;
		pllc <= 1'b0;
		por <= 1'b1;
		repeat (5) @(posedge clk);
		ck({7'h00, trst}, 8'h01);
		host.io(1'b0, OFS_STATUS_A, 8'h00, q, oe);
		ck({7'h00, oe}, 8'h00);
		good <= 1'b1;
		por <= 1'b0;
		repeat (5) @(negedge clk);
		ck({7'h00, trst}, 8'h00);
	endtask : t_pll
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		@(negedge clk);
		ck(doc, DOC_RESET);
		ck(rsc, RSC_RESET);
		ck(rcw, RCW_RESET);
		wr(OFS_DRIVE_OUTPUT, 8'h0C);
		t_asleep();
		t_store();
		t_data();
		t_swreset();
		t_direct();
		t_pll();
		finish_test();
	end
endmodule : tb_top
bind fdc_pm_seq fdc_pm_seq_chk chk (.MCLK(MCLK), .RESET(RESET), .SA(SA), .SD_OE(SD_OE),
	.INTERNAL_SUPPLY_GOOD(INTERNAL_SUPPLY_GOOD), .POWER_CONTROL_CONFIG_7(POWER_CONTROL_CONFIG_7),
	.PLL_CONFIG_1(PLL_CONFIG_1), .POWERED_DOWN(POWERED_DOWN), .CORE_RESET(CORE_RESET), .IRQ(IRQ), .DRQ(DRQ),
	.DRIVE_PINS_EN(DRIVE_PINS_EN), .PLL14_POWER(PLL14_POWER), .PLL32_POWER(PLL32_POWER));
